// ===== rtl/docc_top.sv
// DAC output connect control: soft/hard connect, reprogramming, tracking, APB registers
// ----------------------------------------------------------------------
// Notes on behaviour
// - Tracking steps the code one count toward the ramp target.
// - Ramp enable bit zero inhibits tracking, one permits it.
// - Each channel holds a 10-bit read/write ramp start delay.
// - Soft connect steps code until the match comparator output changes.
// - Link the buffer only if the trip is reached without a DAC fault.
// - Soft connect ignores written code and starts at mid-scale 0x80.
// - Comparator trip links the buffer and sets output-linked status.
// - Reaching 0x00 or 0xFF untripped fails, sets fault, stays unlinked.
// - Channel 0 soft connect is served before channel 1.
// - Busy or failed soft connect ignores soft requests, locks polarity and code.
// - Tracking configured or pending ignores soft requests and locks polarity.
// - Hard connect links at once using the written code.
// - Extreme codes are accepted on hard connect or reprogram but set fault.
// - Hard connect and its fields lock while busy, failed or tracking.
// - Connected DAC takes a new written code only while its servo loop is off.
// - Clearing output-linked alone keeps the link; clearing enable disconnects unless busy or tracking.
// - Enable with linked low is soft connect, with linked high hard.
// - Delay counts down at fixed rate, then stepping; enable clears at target.
// ----------------------------------------------------------------------
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module docc_top #(
   parameter int unsigned SC_DIV = docc_pkg::SC_STEP_CYC,
   parameter int unsigned TRK_DIV = docc_pkg::TRK_DEC_CYC
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [1:0] MATCH_COMPARATOR_OUT,
   input wire logic SEQ_CFG_PIN,
   input wire logic [1:0] RUN_CTRL_PIN,
   input wire logic [1:0] SERVO_EN,
   output logic [7:0] DAC_CODE0,
   output logic [7:0] DAC_CODE1,
   output logic [1:0] BUF_TO_PIN_LINK,
   output logic [1:0] TRIM_OUTPUT_EN,
   output logic [1:0] DAC_FAULT
);
   import docc_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [1:0] comp_s;
   logic seq_cfg_s;
   logic [1:0] run_s;

   docc_pin_sync #(.W(2)) u_sync_comp (
      .clk(REF_CLK),
      .rst(RST),
      .pin_in(MATCH_COMPARATOR_OUT),
      .level(comp_s)
   );

   docc_pin_sync #(.W(3)) u_sync_trk (
      .clk(REF_CLK),
      .rst(RST),
      .pin_in({SEQ_CFG_PIN, RUN_CTRL_PIN}),
      .level({seq_cfg_s, run_s})
   );

   wire trk_cfg = seq_cfg_s & (run_s[0] | run_s[1]);

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire apb_setup = PSEL & ~PENABLE;
   wire apb_access = PSEL & PENABLE;
   wire apb_wr = apb_access & PWRITE;
   wire hit_ctrl0 = (PADDR == OFS_CH0_DAC_CTRL);
   wire hit_ctrl1 = (PADDR == OFS_CH1_DAC_CTRL);
   wire hit_tgt0 = (PADDR == OFS_CH0_RAMP_TARGET_CTRL);
   wire hit_tgt1 = (PADDR == OFS_CH1_RAMP_TARGET_CTRL);
   wire hit_dly0 = (PADDR == OFS_CH0_RAMP_START_DELAY);
   wire hit_dly1 = (PADDR == OFS_CH1_RAMP_START_DELAY);
   wire hit_stat = (PADDR == OFS_STATUS);
   wire mapped = hit_ctrl0 | hit_ctrl1 | hit_tgt0 | hit_tgt1 | hit_dly0 | hit_dly1 | hit_stat;
   wire [1:0] wr_ctrl = {apb_wr & hit_ctrl1, apb_wr & hit_ctrl0};
   wire [1:0] wr_tgt = {apb_wr & hit_tgt1, apb_wr & hit_tgt0};
   wire [1:0] wr_dly = {apb_wr & hit_dly1, apb_wr & hit_dly0};
   wire wr_stat = apb_wr & hit_stat;
   wire [1:0] fault_clr = wr_stat ? PWDATA[STAT_FAULT_LSB +: 2] : 2'b00;
   wire trk_start = wr_stat & PWDATA[STAT_TRK_START_BIT];

   docc_dac_ctrl_t wd;
   assign wd = docc_dac_ctrl_t'(PWDATA[CTRL_W-1:0]);

   assign PREADY = apb_access;
   assign PSLVERR = apb_access & ~mapped;

   // ----------------------------------------------------------------
   // Channel state
   // ----------------------------------------------------------------
   docc_dac_ctrl_t ctrl [2];
   docc_tgt_t tgt [2];
   logic [DLY_W-1:0] dly [2];
   logic [DLY_W-1:0] trk_cnt [2];
   logic [1:0] trk_act;
   logic [1:0] fault;
   logic [1:0] sc_pend;
   logic [1:0] sc_busy;
   logic [1:0] sc_load;
   logic [1:0] sc_step;
   logic [1:0] sc_ok;
   logic [1:0] sc_fail;
   logic sc_up;
   logic sc_tick;
   logic trk_tick;

   wire trk_busy = |trk_act;

   docc_tick_div #(.DIV(TRK_DIV)) u_trk_div (
      .clk(REF_CLK),
      .rst(RST),
      .run(trk_busy),
      .tick(trk_tick)
   );

   // ----------------------------------------------------------------
   // Soft connect engine, shared by both channels
   // ----------------------------------------------------------------
   docc_sc_state_t sc_state;
   docc_sc_state_t next_sc_state;
   logic sc_ch;
   logic comp_ref;

   wire sc_run = (sc_state != SC_IDLE);
   wire comp_sel = sc_ch ? comp_s[1] : comp_s[0];
   wire [7:0] code_sel = sc_ch ? ctrl[1].code : ctrl[0].code;
   wire grant0 = (sc_state == SC_IDLE) & sc_pend[0];
   wire grant1 = (sc_state == SC_IDLE) & ~sc_pend[0] & sc_pend[1];
   wire ramp_tick = (sc_state == SC_RAMP) & sc_tick;
   wire trip = ramp_tick & (comp_sel != comp_ref);
   // An extreme code counts as a DAC fault, so reaching it untripped ends the ramp
   wire ramp_fail = ramp_tick & ~trip & is_extreme(code_sel);
   wire ramp_step = ramp_tick & ~trip & ~is_extreme(code_sel);

   docc_tick_div #(.DIV(SC_DIV)) u_sc_div (
      .clk(REF_CLK),
      .rst(RST),
      .run(sc_run),
      .tick(sc_tick)
   );

   always_comb begin
      next_sc_state = sc_state;
      case (sc_state)
         SC_IDLE: begin
            if (grant0 | grant1) begin
               next_sc_state = SC_PREP;
            end
         end
         SC_PREP: begin
            if (sc_tick) begin
               next_sc_state = SC_RAMP;
            end
         end
         SC_RAMP: begin
            if (trip | ramp_fail) begin
               next_sc_state = SC_IDLE;
            end
         end
         default: begin
            next_sc_state = SC_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         sc_state <= SC_IDLE;
         sc_ch <= 1'b0;
         comp_ref <= 1'b0;
      end else begin
         sc_state <= next_sc_state;
         if (grant0 | grant1) begin
            sc_ch <= grant1;
         end
         if ((sc_state == SC_PREP) & sc_tick) begin
            comp_ref <= comp_sel;
         end
      end
   end

   // Comparator high means buffer above pin: walk down, otherwise walk up
   assign sc_up = ~comp_ref;
   assign sc_load = {grant1, grant0};
   assign sc_step = {ramp_step & sc_ch, ramp_step & ~sc_ch};
   assign sc_ok = {trip & sc_ch, trip & ~sc_ch};
   assign sc_fail = {ramp_fail & sc_ch, ramp_fail & ~sc_ch};

   // ----------------------------------------------------------------
   // Per-channel control
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 2; g++) begin : g_ch
      wire eng_mine = sc_run & (sc_ch == 1'(g));
      wire lock = sc_busy[g] | fault[g] | trk_cfg | trk_busy;
      wire soft_ok = wr_ctrl[g] & wd.en & ~wd.linked & ~ctrl[g].en & ~lock;
      wire hard_ok = wr_ctrl[g] & wd.en & wd.linked & ~ctrl[g].en & ~lock;
      // Polarity is taken as written on a reprogram, software must preserve it
      wire reprog_ok = wr_ctrl[g] & wd.en & wd.linked & ctrl[g].en & ctrl[g].linked
                       & ~SERVO_EN[g] & ~lock;
      wire disc_ok = wr_ctrl[g] & ~wd.en & ~sc_busy[g] & ~trk_cfg & ~trk_busy;
      wire trk_go = trk_start & tgt[g].en & ctrl[g].linked & ~trk_busy & ~sc_busy[g];
      wire trk_at = trk_act[g] & trk_tick & (trk_cnt[g] == '0);
      wire trk_done = trk_at & (ctrl[g].code == tgt[g].code);
      wire trk_step = trk_at & ~trk_done;
      wire fault_set = sc_fail[g] | ((hard_ok | reprog_ok) & is_extreme(wd.code));
      wire [7:0] sc_next = sc_up ? ctrl[g].code + 8'h01 : ctrl[g].code - 8'h01;

      assign sc_busy[g] = sc_pend[g] | eng_mine;

      always_ff @(posedge REF_CLK or posedge RST) begin
         if (RST) begin
            ctrl[g] <= '{pol: 1'b0, linked: 1'b0, en: 1'b0, code: DAC_CODE_RST};
            sc_pend[g] <= 1'b0;
            fault[g] <= 1'b0;
         end else begin
            fault[g] <= (fault[g] & ~fault_clr[g]) | fault_set;
            if (soft_ok) begin
               sc_pend[g] <= 1'b1;
            end else if (sc_load[g]) begin
               sc_pend[g] <= 1'b0;
            end
            if (sc_load[g]) begin
               ctrl[g].code <= SOFT_START_CODE;
            end else if (sc_step[g]) begin
               ctrl[g].code <= sc_next;
            end else if (trk_step) begin
               ctrl[g].code <= step_toward(ctrl[g].code, tgt[g].code);
            end else if (hard_ok | reprog_ok) begin
               ctrl[g].code <= wd.code;
            end
            if (soft_ok | hard_ok | reprog_ok) begin
               ctrl[g].pol <= wd.pol;
            end
            if (soft_ok | hard_ok) begin
               ctrl[g].en <= 1'b1;
            end else if (disc_ok) begin
               ctrl[g].en <= 1'b0;
            end
            if (sc_ok[g] | hard_ok) begin
               ctrl[g].linked <= 1'b1;
            end else if (disc_ok) begin
               ctrl[g].linked <= 1'b0;
            end
         end
      end

      // Tracking registers and delay countdown
      always_ff @(posedge REF_CLK or posedge RST) begin
         if (RST) begin
            tgt[g] <= '{en: 1'b0, code: TGT_CODE_RST};
            dly[g] <= DLY_RST;
            trk_cnt[g] <= DLY_RST;
            trk_act[g] <= 1'b0;
         end else begin
            if (wr_tgt[g] & ~trk_busy) begin
               tgt[g] <= docc_tgt_t'(PWDATA[TGT_W-1:0]);
            end else if (trk_done) begin
               tgt[g].en <= 1'b0;
            end
            if (wr_dly[g]) begin
               dly[g] <= PWDATA[DLY_W-1:0];
            end
            if (trk_go) begin
               trk_act[g] <= 1'b1;
               trk_cnt[g] <= dly[g];
            end else if (trk_done) begin
               trk_act[g] <= 1'b0;
            end else if (trk_act[g] & trk_tick & (trk_cnt[g] != '0)) begin
               trk_cnt[g] <= trk_cnt[g] - 10'h001;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   wire [31:0] rd_ctrl0 = {21'h00_0000, ctrl[0]};
   wire [31:0] rd_ctrl1 = {21'h00_0000, ctrl[1]};
   wire [31:0] rd_tgt0 = {23'h00_0000, tgt[0]};
   wire [31:0] rd_tgt1 = {23'h00_0000, tgt[1]};
   wire [31:0] rd_dly0 = {22'h00_0000, dly[0]};
   wire [31:0] rd_dly1 = {22'h00_0000, dly[1]};
   wire [31:0] rd_stat = {26'h000_0000, trk_cfg, trk_busy, sc_busy, fault};
   wire [31:0] rd_data = hit_ctrl0 ? rd_ctrl0 :
                         hit_ctrl1 ? rd_ctrl1 :
                         hit_tgt0 ? rd_tgt0 :
                         hit_tgt1 ? rd_tgt1 :
                         hit_dly0 ? rd_dly0 :
                         hit_dly1 ? rd_dly1 :
                         hit_stat ? rd_stat : RD_ZERO;

   // Read data is captured in the setup cycle so the access phase needs no wait
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         PRDATA <= RD_ZERO;
      end else if (apb_setup & ~PWRITE) begin
         PRDATA <= rd_data;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign DAC_CODE0 = ctrl[0].code;
   assign DAC_CODE1 = ctrl[1].code;
   assign BUF_TO_PIN_LINK = {ctrl[1].linked, ctrl[0].linked};
   assign TRIM_OUTPUT_EN = {ctrl[1].en, ctrl[0].en};
   assign DAC_FAULT = fault;

endmodule : docc_top

// ===== inc/docc_pkg.sv
// Shared constants, types and helpers of the DAC output connect control block
package docc_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int SC_STEP_NS = 1000;
   localparam int SC_STEP_CYC = (SC_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRK_DEC_NS = 10000;
   localparam int TRK_DEC_CYC = (TRK_DEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CH0_DAC_CTRL = 8'h00;
   localparam logic [7:0] OFS_CH1_DAC_CTRL = 8'h04;
   localparam logic [7:0] OFS_CH0_RAMP_TARGET_CTRL = 8'h08;
   localparam logic [7:0] OFS_CH1_RAMP_TARGET_CTRL = 8'h0C;
   localparam logic [7:0] OFS_CH0_RAMP_START_DELAY = 8'h10;
   localparam logic [7:0] OFS_CH1_RAMP_START_DELAY = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_W = 11;
   localparam int TGT_W = 9;
   localparam int TGT_EN_BIT = 8;
   localparam int DLY_W = 10;
   localparam int STAT_FAULT_LSB = 0;
   localparam int STAT_SC_BUSY_LSB = 2;
   localparam int STAT_TRK_BUSY_BIT = 4;
   localparam int STAT_TRK_CFG_BIT = 5;
   localparam int STAT_TRK_START_BIT = 8;

   // ----------------------------------------------------------------
   // Codes and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] SOFT_START_CODE = 8'h80;
   localparam logic [7:0] CODE_MIN = 8'h00;
   localparam logic [7:0] CODE_MAX = 8'hFF;
   localparam logic [7:0] DAC_CODE_RST = 8'h80;
   localparam logic [7:0] TGT_CODE_RST = 8'h00;
   localparam logic [DLY_W-1:0] DLY_RST = 10'h000;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic pol;
      logic linked;
      logic en;
      logic [7:0] code;
   } docc_dac_ctrl_t;

   typedef struct packed {
      logic en;
      logic [7:0] code;
   } docc_tgt_t;

   typedef enum logic [2:0] {
      SC_IDLE = 3'b001,
      SC_PREP = 3'b010,
      SC_RAMP = 3'b100
   } docc_sc_state_t;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic is_extreme(input logic [7:0] code);
      is_extreme = (code == CODE_MIN) || (code == CODE_MAX);
   endfunction : is_extreme

   function automatic logic [7:0] step_toward(input logic [7:0] code, input logic [7:0] tgt);
      if (code < tgt) begin
         step_toward = code + 8'h01;
      end else if (code > tgt) begin
         step_toward = code - 8'h01;
      end else begin
         step_toward = code;
      end
   endfunction : step_toward

endpackage : docc_pkg

// ===== rtl/docc_pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
module docc_pin_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // Only stage two and three are compared; stage one may be metastable
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         level <= '0;
      end else begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
         for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
               level[i] <= s3[i];
            end
         end
      end
   end
endmodule : docc_pin_sync

// ===== rtl/docc_tick_div.sv
// Divider that gives a one-cycle enable pulse every DIV cycles while running
`timescale 1ns/1ns
module docc_tick_div #(
   parameter int unsigned DIV = 100
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   output logic tick
);
   logic [15:0] cnt;
   localparam logic [15:0] LAST = 16'(DIV - 1);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= '0;
         tick <= 1'b0;
      end else if (!run) begin
         cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (cnt == LAST);
         cnt <= (cnt == LAST) ? 16'h0000 : cnt + 16'h0001;
      end
   end
endmodule : docc_tick_div

// ===== sim/docc_trim_model.sv
// Behavioural match comparator of the external supply trim node, one per channel
`timescale 1ns/1ns
module docc_trim_model (
   input wire logic [7:0] code0,
   input wire logic [7:0] code1,
   input wire logic [7:0] lvl0,
   input wire logic [7:0] lvl1,
   output logic [1:0] comp
);
   // High while the buffered DAC voltage sits above the pin voltage
   assign comp[0] = code0 > lvl0;
   assign comp[1] = code1 > lvl1;
endmodule : docc_trim_model

// ===== sim/docc_chk.sv
// Concurrent assertions on the DAC output connect control top-level ports
`timescale 1ns/1ns
module docc_chk (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic SEQ_CFG_PIN,
   input wire logic [1:0] RUN_CTRL_PIN,
   input wire logic [7:0] DAC_CODE0,
   input wire logic [1:0] BUF_TO_PIN_LINK,
   input wire logic [1:0] TRIM_OUTPUT_EN,
   input wire logic [1:0] DAC_FAULT
);
   wire wr = PSEL && PENABLE && PWRITE;
   default clocking @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   a_soft_start_mid: assert property (
      $rose(TRIM_OUTPUT_EN[0]) && !BUF_TO_PIN_LINK[0] |-> ##[0:4] DAC_CODE0 == 8'h80)
      else $error("soft connect did not start at mid-scale");
   a_step_one_count: assert property (
      $past(BUF_TO_PIN_LINK[0]) && BUF_TO_PIN_LINK[0] && !$past(wr) && $changed(DAC_CODE0)
      |-> (DAC_CODE0 - $past(DAC_CODE0) == 8'h01) || ($past(DAC_CODE0) - DAC_CODE0 == 8'h01))
      else $error("linked code moved by more than one count");
   a_link_needs_en: assert property (
      BUF_TO_PIN_LINK[0] |-> TRIM_OUTPUT_EN[0]) else $error("link without output enable");
   a_link_no_fault: assert property (
      $rose(BUF_TO_PIN_LINK[0]) && !$past(wr) |-> !DAC_FAULT[0])
      else $error("soft link made with fault set");
   a_fault_at_end: assert property (
      $rose(DAC_FAULT[0]) |-> DAC_CODE0 == 8'h00 || DAC_CODE0 == 8'hFF)
      else $error("fault raised away from an end code");
   a_extreme_flag: assert property (
      $past(wr) && $rose(BUF_TO_PIN_LINK[0]) && (DAC_CODE0 == 8'h00 || DAC_CODE0 == 8'hFF)
      |-> DAC_FAULT[0]) else $error("extreme hard code without fault");
   a_disc_keeps: assert property (
      $fell(TRIM_OUTPUT_EN[0]) |-> $stable(DAC_CODE0) && !BUF_TO_PIN_LINK[0])
      else $error("disconnect changed code or kept link");
   a_track_lock: assert property (
      (SEQ_CFG_PIN && RUN_CTRL_PIN != 2'b00) [*6]
      |=> (TRIM_OUTPUT_EN & ~$past(TRIM_OUTPUT_EN)) == 2'b00)
      else $error("connect accepted while tracking configured");
endmodule : docc_chk

bind docc_top docc_chk docc_chk_i (.REF_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .SEQ_CFG_PIN,
   .RUN_CTRL_PIN, .DAC_CODE0, .BUF_TO_PIN_LINK, .TRIM_OUTPUT_EN, .DAC_FAULT);

// ===== sim/docc_top_bench.sv
// Self-checking bench for the DAC output connect control block
`timescale 1ns/1ns
module docc_top_bench;
   import docc_pkg::*;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, seq = 0, er;
   logic [7:0] pa = 8'h00, l0 = 8'h7C, l1 = 8'h85, c0, c1;
   logic [31:0] pwd = 32'h0000_0000, prd, rd;
   logic rdy, slv;
   logic [1:0] run = 2'b00, srv = 2'b00, cmpo, lnk, oen, flt;
   int error_cnt = 0, checks = 0;

   always #5 clk = ~clk;

   // Short step dividers keep ramps within the run budget
   docc_top #(.SC_DIV(8), .TRK_DIV(4)) docc_top_i (.REF_CLK(clk), .RST(rst), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy),
      .PSLVERR(slv), .MATCH_COMPARATOR_OUT(cmpo), .SEQ_CFG_PIN(seq), .RUN_CTRL_PIN(run),
      .SERVO_EN(srv), .DAC_CODE0(c0), .DAC_CODE1(c1), .BUF_TO_PIN_LINK(lnk),
      .TRIM_OUTPUT_EN(oen), .DAC_FAULT(flt));
   docc_trim_model docc_trim_model_i (.code0(c0), .code1(c1), .lvl0(l0), .lvl1(l1),
      .comp(cmpo));

   // ----------------------------------------------------------------
   // Bus and check tasks
   // ----------------------------------------------------------------
   task automatic stop_test;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   // Ends one edge after the access so registered results have landed
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      for (n = 0; n < 16 && rdy !== 1'b1; n++) begin
         @(posedge clk);
      end
      if (n == 16) begin
         error_cnt++;
         stop_test();
      end
      rd = prd;
      er = slv;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic chk(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0000_0000);
      cmp(nm, e, rd);
   endtask : chk

   task automatic wait_for(input logic [1:0] m);
      int n;
      for (n = 0; n < 3000 && ((lnk | flt) & m) === 2'b00; n++) begin
         @(posedge clk);
      end
      if (n == 3000) begin
         error_cnt++;
         stop_test();
      end
   endtask : wait_for

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         chk(8'(8'h08 + 4 * i), 32'h0000_0000, "track reg reset");
      end
      wr(OFS_CH0_RAMP_START_DELAY, 32'hFFFF_FFFF);
      chk(OFS_CH0_RAMP_START_DELAY, 32'h0000_03FF, "delay0");
      wr(OFS_CH1_RAMP_TARGET_CTRL, 32'hFFFF_FE12);
      chk(OFS_CH1_RAMP_TARGET_CTRL, 32'h0000_0012, "target1");
      apb(1'b0, 8'h1C, 32'h0000_0000);
      cmp("unmapped error", 32'h0000_0001, er);
      // Soft connects: ch0 ramps down, ch1 queued behind it ramps up
      wr(OFS_CH0_DAC_CTRL, 32'h0000_0533);
      wr(OFS_CH1_DAC_CTRL, 32'h0000_0500);
      wr(OFS_CH0_DAC_CTRL, 32'h0000_0111);
      chk(OFS_STATUS, 32'h0000_000C, "busy while ramping");
      wait_for(2'b01);
      cmp("ch1 link while ch0 ramps", 32'h0000_0000, lnk[1]);
      chk(OFS_CH0_DAC_CTRL, 32'h0000_077C, "ch0 ctrl after soft");
      wait_for(2'b10);
      cmp("ch1 trip code", 32'h0000_0086, c1);
      cmp("faults after soft", 32'h0000_0000, flt);
      // Reprogram, loop-enable lock, link-bit-only clear, disconnect
      wr(OFS_CH0_DAC_CTRL, 32'h0000_0790);
      cmp("reprogram code", 32'h0000_0090, c0);
      srv <= 2'b01;
      wr(OFS_CH0_DAC_CTRL, 32'h0000_0755);
      cmp("servo blocks reprogram", 32'h0000_0090, c0);
      srv <= 2'b00;
      wr(OFS_CH0_DAC_CTRL, 32'h0000_0590);
      cmp("link bit alone", 32'h0000_0001, lnk[0]);
      wr(OFS_CH0_DAC_CTRL, 32'h0000_0490);
      cmp("disconnect", 32'h0000_0090, {oen[0], lnk[0], c0});
      // Hard connect and reprogram with end codes
      wr(OFS_CH0_DAC_CTRL, 32'h0000_07FF);
      cmp("hard ff", 32'h0000_03FF, {lnk[0], flt[0], c0});
      wr(OFS_CH1_DAC_CTRL, 32'h0000_0700);
      cmp("reprogram 00", 32'h0000_0300, {lnk[1], flt[1], c1});
      wr(OFS_CH0_DAC_CTRL, 32'h0000_04FF);
      wr(OFS_CH1_DAC_CTRL, 32'h0000_0400);
      wr(OFS_STATUS, 32'h0000_0003);
      cmp("fault clear", 32'h0000_0000, flt);
      // Failed soft connect and the locks it leaves behind
      l0 <= 8'hFF;
      wr(OFS_CH0_DAC_CTRL, 32'h0000_0500);
      wait_for(2'b01);
      cmp("soft fail", 32'h0000_05FF, {oen[0], lnk[0], flt[0], c0});
      wr(OFS_CH0_DAC_CTRL, 32'h0000_04FF);
      wr(OFS_CH0_DAC_CTRL, 32'h0000_0500);
      cmp("soft after fail", 32'h0000_0000, oen[0]);
      wr(OFS_CH0_DAC_CTRL, 32'h0000_0740);
      cmp("hard after fail", 32'h0000_00FF, {oen[0], c0});
      wr(OFS_STATUS, 32'h0000_0001);
      // Tracking configured by pins locks both connect kinds
      seq <= 1'b1;
      run <= 2'b10;
      repeat (8) @(posedge clk);
      wr(OFS_CH0_DAC_CTRL, 32'h0000_0740);
      wr(OFS_CH0_DAC_CTRL, 32'h0000_0500);
      cmp("pins lock", 32'h0000_00FF, {oen[0], c0});
      chk(OFS_STATUS, 32'h0000_0020, "tracking configured");
      seq <= 1'b0;
      run <= 2'b00;
      repeat (8) @(posedge clk);
      // Tracking ch0 to its target; ch1 inhibited
      wr(OFS_CH0_DAC_CTRL, 32'h0000_0740);
      wr(OFS_CH1_DAC_CTRL, 32'h0000_0720);
      wr(OFS_CH0_RAMP_TARGET_CTRL, 32'h0000_0144);
      wr(OFS_CH0_RAMP_START_DELAY, 32'h0000_0003);
      wr(OFS_STATUS, 32'h0000_0100);
      cmp("delay holds code", 32'h0000_0040, c0);
      chk(OFS_STATUS, 32'h0000_0010, "tracking busy");
      for (int n = 0; n < 100; n++) begin
         apb(1'b0, OFS_CH0_RAMP_TARGET_CTRL, 32'h0000_0000);
         if (rd[8] === 1'b0) begin
            break;
         end
      end
      cmp("ramp enable cleared", 32'h0000_0044, rd);
      cmp("tracked code", 32'h0000_0044, c0);
      cmp("inhibited channel", 32'h0000_0020, c1);
      stop_test();
   end

   initial begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      stop_test();
   end
endmodule : docc_top_bench
